//--- hdl/dsf_pkg.sv
// package: offsets, reset values, states and carriers of the dma feed
package dsf_pkg;

	localparam int unsigned ADDR_W        = 12;
	localparam logic [11:0] OFF_TALLY     = 12'h2F8;
	localparam logic [11:0] OFF_FILL      = 12'h2FC;
	localparam logic [11:0] OFF_BASE      = 12'h308;
	localparam logic [11:0] OFF_LEN       = 12'h30C;
	localparam logic [11:0] OFF_NEXT      = 12'h310;
	localparam logic [11:0] OFF_STAT      = 12'h314;

	localparam int unsigned TALLY_W       = 28;
	localparam int unsigned LEN_W         = 28;
	localparam int unsigned FIFO_BYTES    = 32768;
	localparam int unsigned VALUE_BYTES   = 2;
	localparam int unsigned VALUE_W       = 16;
	localparam int unsigned FIFO_VALUES   = FIFO_BYTES / VALUE_BYTES;
	localparam int unsigned VAL_PER_DAC   = 4;
	localparam int unsigned WORD_BYTES    = 4;
	localparam int unsigned PEND_W        = 16;
	localparam int unsigned DAC_CNT_W     = 3;

	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_FULL_BIT = 1;

	localparam logic [31:0] RST_BASE      = 32'h0000_0000;
	localparam logic [27:0] RST_LEN       = 28'h000_0000;
	localparam logic [27:0] RST_TALLY     = 28'h000_0000;
	localparam logic [31:0] RST_PTR       = 32'h0000_0000;

	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [4:0] {
		DMA_IDLE = 5'b00001,
		DMA_REQ  = 5'b00010,
		DMA_WAIT = 5'b00100,
		DMA_LO   = 5'b01000,
		DMA_HI   = 5'b10000
	} dsf_dma_st_t;

	// sequencer side controls, same clock as the feed
	typedef struct packed {
		logic                 conv_pulse;
		logic                 conv_start;
		logic                 frame_trig;
		logic                 frame_err;
		logic                 frame_mode;
		logic [DAC_CNT_W-1:0] dac_count;
	} dsf_seq_ctl_t;

	// one word returned by host memory
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} dsf_fetch_rsp_t;

endpackage

//--- hdl/dsf_top.sv
// dma feed of the d/a sequencer: fifo, register slave and fetch engine
//
// Overview of operation
// - count conversions of the current block or frame in 28 bits
// - counter wraps to zero after its maximum, no error raised
// - normal mode: clear counter when a conversion process starts
// - frame mode: clear counter at frame trigger unless frame error
// - report fifo fill level as a 32-bit byte count
// - each stored value is two bytes, level rises by two
// - fifo holds 32 kilobytes of conversion data
// - base register holds 32-bit host buffer address
// - base captured on length write, next base may follow at once
// - 28-bit length in bytes; writing it launches a transfer
// - launch only when engine idle and written length nonzero
// - read-only register shows the next host fetch address
// - each conversion consumes four values per assigned dac device
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module dsf_fifo
	import dsf_pkg::*;
#(
	parameter int unsigned WIDTH = VALUE_W,
	parameter int unsigned DEPTH = FIFO_VALUES,
	localparam int unsigned AW   = $clog2(DEPTH)
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [AW:0]      level
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} dsf_fifo_state_t;

	dsf_fifo_state_t s_r;
	dsf_fifo_state_t s_nxt;
	logic            push;
	logic            pop;

	assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s_r.cnt != '0);
	assign out_data  = s_r.mem[s_r.rp];
	assign level     = s_r.cnt;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

module dsf_top
	import dsf_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = FIFO_VALUES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   fetch_valid,
	input  wire logic              fetch_ready,
	output logic [31:0]            fetch_addr,
	input  wire dsf_fetch_rsp_t    fetch_rsp,
	input  wire dsf_seq_ctl_t      seq_ctl,
	output logic                   dac_value_valid,
	input  wire logic              dac_value_ready,
	output logic [VALUE_W-1:0]     dac_value
);

	localparam int unsigned AW = $clog2(FIFO_DEPTH);

	typedef struct packed {
		logic                awh;
		logic [ADDR_W-1:0]   aw_addr;
		logic                wh;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [31:0]         base;
		logic [LEN_W-1:0]    len;
		logic [31:0]         ptr;
		logic [LEN_W-1:0]    remain;
		logic [2:0]          chunk;
		logic [31:0]         word;
		dsf_dma_st_t         st;
		logic [TALLY_W-1:0]  tally;
		logic [PEND_W-1:0]   pend;
	} dsf_top_state_t;

	dsf_top_state_t     s_r;
	dsf_top_state_t     s_nxt;
	logic               q_in_valid;
	logic               q_in_ready;
	logic [VALUE_W-1:0] q_in_data;
	logic               q_out_valid;
	logic               q_out_ready;
	logic [AW:0]        q_level;
	logic [31:0]        fill_bytes;
	logic               do_wr;
	logic               wr_len;
	logic [31:0]        len_wdata;
	logic               launch;
	logic               tally_clr;
	logic [2:0]         take;
	logic               q_push;
	logic               q_pop;

	function automatic logic [31:0] dsf_merge(
		input logic [31:0] old,
		input logic [31:0] d,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic dsf_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off
	);
		return a[ADDR_W-1:2] == off[ADDR_W-1:2];
	endfunction

	dsf_fifo #(
		.WIDTH     (VALUE_W),
		.DEPTH     (FIFO_DEPTH)
	) u_queue (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (q_in_valid),
		.in_ready  (q_in_ready),
		.in_data   (q_in_data),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (dac_value),
		.level     (q_level)
	);

	assign fill_bytes = {{(30-AW){1'b0}}, q_level, 1'b0};

	assign s_axi_awready = !s_r.awh && !s_r.bvalid;
	assign s_axi_wready  = !s_r.wh && !s_r.bvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;

	assign do_wr     = s_r.awh && s_r.wh && !s_r.bvalid;
	assign wr_len    = do_wr && dsf_hit(s_r.aw_addr, OFF_LEN);
	assign len_wdata = dsf_merge({4'h0, s_r.len}, s_r.w_data, s_r.w_strb);
	assign launch    = wr_len && (s_r.st == DMA_IDLE)
		&& (len_wdata[LEN_W-1:0] != '0);

	assign take = (s_r.remain >= LEN_W'(WORD_BYTES)) ? 3'(WORD_BYTES)
		: s_r.remain[2:0];

	assign fetch_valid = (s_r.st == DMA_REQ);
	assign fetch_addr  = s_r.ptr;
	assign q_in_valid  = (s_r.st == DMA_LO) || (s_r.st == DMA_HI);
	assign q_in_data   = (s_r.st == DMA_HI) ? s_r.word[31:16]
		: s_r.word[15:0];
	assign q_push      = q_in_valid && q_in_ready;

	// drain only what conversions asked for
	assign dac_value_valid = q_out_valid && (s_r.pend != '0);
	assign q_out_ready     = dac_value_ready && (s_r.pend != '0);
	assign q_pop           = q_out_valid && q_out_ready;

	// process start in normal mode; frame trigger in frame mode, not on frame error
	assign tally_clr = seq_ctl.frame_mode
		? (seq_ctl.frame_trig && !seq_ctl.frame_err)
		: seq_ctl.conv_start;

	always_comb begin
		s_nxt = s_r;
		// register slave: address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.awh = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.wh = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.awh = 1'b0;
			s_nxt.wh = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			if (dsf_hit(s_r.aw_addr, OFF_BASE)) begin
				s_nxt.base = dsf_merge(s_r.base, s_r.w_data, s_r.w_strb);
			end else if (wr_len) begin
				s_nxt.len = len_wdata[LEN_W-1:0];
			end else if (!dsf_hit(s_r.aw_addr, OFF_TALLY)
				&& !dsf_hit(s_r.aw_addr, OFF_FILL)
				&& !dsf_hit(s_r.aw_addr, OFF_NEXT)
				&& !dsf_hit(s_r.aw_addr, OFF_STAT)) begin
				s_nxt.bresp = RESP_SLVERR;
			end
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (dsf_hit(s_axi_araddr, OFF_TALLY)) begin
				s_nxt.rdata = {4'h0, s_r.tally};
			end else if (dsf_hit(s_axi_araddr, OFF_FILL)) begin
				s_nxt.rdata = fill_bytes;
			end else if (dsf_hit(s_axi_araddr, OFF_BASE)) begin
				s_nxt.rdata = s_r.base;
			end else if (dsf_hit(s_axi_araddr, OFF_LEN)) begin
				s_nxt.rdata = {4'h0, s_r.len};
			end else if (dsf_hit(s_axi_araddr, OFF_NEXT)) begin
				s_nxt.rdata = s_r.ptr;
			end else if (dsf_hit(s_axi_araddr, OFF_STAT)) begin
				s_nxt.rdata[STAT_BUSY_BIT] = (s_r.st != DMA_IDLE);
				s_nxt.rdata[STAT_FULL_BIT] = !q_in_ready;
			end else begin
				s_nxt.rresp = RESP_SLVERR;
			end
		end

		// fetch engine; a short last word still fills a whole value
		case (s_r.st)
			DMA_IDLE: begin
				if (launch) begin
					s_nxt.ptr = s_r.base;
					s_nxt.remain = len_wdata[LEN_W-1:0];
					s_nxt.st = DMA_REQ;
				end
			end
			DMA_REQ: begin
				if (fetch_ready) begin
					s_nxt.st = DMA_WAIT;
				end
			end
			DMA_WAIT: begin
				if (fetch_rsp.valid) begin
					s_nxt.word = fetch_rsp.data;
					s_nxt.ptr = s_r.ptr + 32'(take);
					s_nxt.remain = s_r.remain - LEN_W'(take);
					s_nxt.chunk = take;
					s_nxt.st = DMA_LO;
				end
			end
			DMA_LO: begin
				if (q_in_ready) begin
					if (s_r.chunk >= 3'd3) begin
						s_nxt.st = DMA_HI;
					end else if (s_r.remain == '0) begin
						s_nxt.st = DMA_IDLE;
					end else begin
						s_nxt.st = DMA_REQ;
					end
				end
			end
			DMA_HI: begin
				if (q_in_ready) begin
					s_nxt.st = (s_r.remain == '0) ? DMA_IDLE : DMA_REQ;
				end
			end
			default: begin
				s_nxt.st = DMA_IDLE;
			end
		endcase

		// count, clear first then this cycle's conversion
		// natural wrap of the 28-bit count
		if (tally_clr) begin
			s_nxt.tally = TALLY_W'(seq_ctl.conv_pulse);
		end else if (seq_ctl.conv_pulse) begin
			s_nxt.tally = s_r.tally + 1'b1;
		end

		// four values per assigned dac and conversion
		s_nxt.pend = s_r.pend - PEND_W'(q_pop);
		if (seq_ctl.conv_pulse) begin
			s_nxt.pend = s_nxt.pend
				+ PEND_W'(VAL_PER_DAC * int'(seq_ctl.dac_count));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r        <= '0;
			s_r.base   <= RST_BASE;
			s_r.len    <= RST_LEN;
			s_r.ptr    <= RST_PTR;
			s_r.tally  <= RST_TALLY;
			s_r.st     <= DMA_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	default clocking dsf_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	localparam logic [TALLY_W-1:0] TALLY_MAX = '1;

	chk_tally_counts: assert property (
		seq_ctl.conv_pulse && !tally_clr && s_r.tally != TALLY_MAX
		|=> s_r.tally == $past(s_r.tally) + 1'b1)
		else $error("tally did not count a conversion");

	chk_tally_wrap: assert property (
		seq_ctl.conv_pulse && !tally_clr && s_r.tally == TALLY_MAX
		|=> s_r.tally == '0)
		else $error("tally did not wrap to zero");

	chk_normal_clear: assert property (
		!seq_ctl.frame_mode && seq_ctl.conv_start && !seq_ctl.conv_pulse
		|=> s_r.tally == '0)
		else $error("tally not cleared at process start");

	chk_frame_keep: assert property (
		seq_ctl.frame_mode && seq_ctl.frame_trig && seq_ctl.frame_err
		&& !seq_ctl.conv_pulse |=> $stable(s_r.tally))
		else $error("tally changed on a frame error trigger");

	chk_frame_clear: assert property (
		seq_ctl.frame_mode && seq_ctl.frame_trig && !seq_ctl.frame_err
		&& !seq_ctl.conv_pulse |=> s_r.tally == '0)
		else $error("tally not cleared at frame trigger");

	chk_fill_step: assert property (
		q_push && !q_pop |=> fill_bytes == $past(fill_bytes) + 32'd2)
		else $error("fill level did not rise by two");

	chk_fifo_cap: assert property (
		!q_in_ready |-> fill_bytes == 32'(FIFO_DEPTH * VALUE_BYTES))
		else $error("queue refused data below capacity");

	sequence s_go;
		launch;
	endsequence

	sequence s_fetch_begin;
		fetch_valid && fetch_addr == $past(s_r.base);
	endsequence

	chk_base_capture: assert property (
		s_go |=> s_fetch_begin)
		else $error("launch did not fetch from the base address");

	chk_launch_gate: assert property (
		wr_len && s_r.st == DMA_IDLE && len_wdata[LEN_W-1:0] == '0
		|=> s_r.st == DMA_IDLE)
		else $error("zero length write started a transfer");

	chk_ptr_advance: assert property (
		s_r.st == DMA_WAIT && fetch_rsp.valid
		|=> s_r.ptr == $past(s_r.ptr) + 32'($past(take)))
		else $error("fetch pointer advanced wrongly");

	chk_drain_demand: assert property (
		seq_ctl.conv_pulse && s_r.pend == '0
		|=> s_r.pend == PEND_W'(VAL_PER_DAC
			* int'($past(seq_ctl.dac_count))))
		else $error("conversion demand not four values per dac");

endmodule

//--- verification/dsf_host_mem.sv
// host memory model answering the feed's word fetches
`timescale 1ns/1ps

module dsf_host_mem
	import dsf_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        slow,
	input  wire logic        fetch_valid,
	output logic             fetch_ready,
	input  wire logic [31:0] fetch_addr,
	output dsf_fetch_rsp_t   fetch_rsp
);
	logic        pend;
	logic [31:0] a;
	int          dly;

	always @(posedge aclk) begin
		if (!aresetn) begin
			fetch_ready <= 1'h0;
			fetch_rsp <= '0;
			pend <= 1'h0;
			a <= 32'h0;
			dly <= 0;
		end else if (pend && dly == 0) begin
			fetch_rsp <= {1'h1, a[15:0] ^ 16'hA5A5, a[15:0]};
			pend <= 1'h0;
		end else begin
			// idle data bus keeps toggling, never holds the last word
			fetch_rsp <= {1'h0, ~fetch_rsp.data};
			if (pend) begin
				dly <= dly - 1;
			end else if (fetch_valid && fetch_ready) begin
				pend <= 1'h1;
				a <= fetch_addr;
				dly <= slow ? int'($urandom % 4) : 0;
				fetch_ready <= 1'h0;
			end else begin
				fetch_ready <= slow ? 1'($urandom) : 1'h1;
			end
		end
	end
endmodule

//--- verification/testbench.sv
// bench of the dma feed: axi-lite master, drain and tally model
`timescale 1ns/1ps

module testbench
	import dsf_pkg::*;
;
	localparam int unsigned DEPTH = 16;
	logic           aclk, aresetn, slow;
	logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic           s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic           s_axi_rvalid, s_axi_rready, fetch_valid, fetch_ready;
	logic           dac_value_valid, dac_value_ready;
	logic [11:0]    s_axi_awaddr, s_axi_araddr;
	logic [31:0]    s_axi_wdata, s_axi_rdata, fetch_addr, d, m_ptr, m_base;
	logic [3:0]     s_axi_wstrb;
	logic [1:0]     s_axi_bresp, s_axi_rresp, r;
	logic [15:0]    dac_value;
	dsf_fetch_rsp_t fetch_rsp;
	dsf_seq_ctl_t   seq_ctl;
	int             errors, comparisons, m_tally, m_pend, m_rem, drained;
	logic [15:0]    m_vals[$];
	logic [11:0]    offs[5] = '{OFF_TALLY, OFF_FILL, OFF_BASE, OFF_LEN,
		OFF_NEXT};
	logic [4:0]     steps[8] = '{5'h04, 5'h08, 5'h08, 5'h02, 5'h18, 5'h13,
		5'h14, 5'h12};

	dsf_top #(.FIFO_DEPTH(DEPTH)) dut (.*);
	dsf_host_mem mem (.*);

	initial begin
		aclk = 1'h0;
		forever #20 aclk = ~aclk;
	end

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_word(input string n, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_value(input string n, input logic [15:0] e,
		input logic [15:0] g);
		cmp_word(n, {16'h0, e}, {16'h0, g});
	endtask

	task automatic cmp_resp(input string n, input logic [1:0] e,
		input logic [1:0] g);
		cmp_word(n, {30'h0, e}, {30'h0, g});
	endtask

	task automatic lapse(input string n);
		errors++;
		$display("BAD %s expected answer seen timeout", n);
		report_and_stop();
	endtask

	// address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (n > 200) lapse("bvalid");
		end while (s_axi_bvalid !== 1'h1);
		resp = s_axi_bresp;
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (n > 200) lapse("rvalid");
		end while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask

	// write plus model: a length write launches only from idle
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic [31:0] p;
		int          k;
		// model first: a fetch may be taken at the edge ending the write
		if (a == OFF_BASE) m_base = v;
		if (a == OFF_LEN && m_rem == 0 && v[27:0] != 28'h0) begin
			m_ptr = m_base;
			m_rem = int'(v[27:0]);
			p = m_base;
			for (k = m_rem; k > 0; k -= 4) begin
				m_vals.push_back(p[15:0]);
				if (k >= 3) m_vals.push_back(p[15:0] ^ 16'hA5A5);
				p += 32'h4;
			end
		end
		axi_wr(a, v, r);
		cmp_resp("bresp", RESP_OKAY, r);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		axi_rd(a, d, r);
		cmp_word($sformatf("reg_%h", a), e, d);
		cmp_resp("rresp", RESP_OKAY, r);
	endtask

	task automatic wait_reg(input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] v);
		int n;
		n = 0;
		do begin
			axi_rd(a, d, r);
			n++;
			if (n > 400) lapse("wait_reg");
		end while ((d & m) !== v);
	endtask

	// one-cycle sequencer pulse; bits are pulse, start, trig, err
	task automatic ctl(input logic m, input logic [2:0] c,
		input logic [3:0] b);
		@(posedge aclk);
		seq_ctl <= {b, m, c};
		@(posedge aclk);
		seq_ctl <= {4'h0, m, c};
		if (m ? (b[1] && !b[0]) : b[2]) m_tally = 0;
		else if (b[3]) m_tally = (m_tally + 1) % (1 << 28);
		if (b[3]) m_pend += VAL_PER_DAC * int'(c);
	endtask

	always @(posedge aclk) begin
		dac_value_ready <= 1'($urandom);
		if (aresetn && fetch_valid && fetch_ready) begin
			cmp_word("fetch_busy", 32'h1, 32'(m_rem > 0));
			cmp_word("fetch_addr", m_ptr, fetch_addr);
			m_ptr += 32'((m_rem < 4) ? m_rem : 4);
			m_rem -= (m_rem < 4) ? m_rem : 4;
		end
		if (aresetn && dac_value_valid && dac_value_ready) begin
			cmp_word("drain_pend", 32'h1, 32'(m_pend > 0));
			cmp_value("dac_value", m_vals.pop_front(), dac_value);
			m_pend--;
			drained++;
		end
	end

	initial begin
		int n;
		void'($urandom(56));
		{aresetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		s_axi_wstrb = 4'hF;
		seq_ctl = '0;
		{errors, comparisons, m_tally, m_pend, m_rem, drained} = '0;
		{m_ptr, m_base} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		foreach (offs[i]) rd_chk(offs[i], 32'h0);
		axi_rd(12'h300, d, r);
		cmp_resp("rresp_unmapped", RESP_SLVERR, r);
		axi_wr(12'h318, 32'h1, r);
		cmp_resp("bresp_unmapped", RESP_SLVERR, r);
		wr(OFF_TALLY, 32'hFFFF_FFFF);
		wr(OFF_FILL, 32'h55);
		rd_chk(OFF_TALLY, 32'h0);
		rd_chk(OFF_FILL, 32'h0);
		// short buffer, two-byte tail, next base loaded at once
		wr(OFF_BASE, 32'h1000_0000);
		wr(OFF_LEN, 32'hA);
		wr(OFF_BASE, 32'h2000_0000);
		wait_reg(OFF_STAT, 32'h1, 32'h0);
		rd_chk(OFF_FILL, 32'hA);
		rd_chk(OFF_NEXT, 32'h1000_000A);
		rd_chk(OFF_BASE, 32'h2000_0000);
		// partial strobe merges only the low bytes
		s_axi_wstrb <= 4'h3;
		axi_wr(OFF_BASE, 32'h1234_5678, r);
		s_axi_wstrb <= 4'hF;
		cmp_resp("bresp_strb", RESP_OKAY, r);
		rd_chk(OFF_BASE, 32'h2000_5678);
		wr(OFF_BASE, 32'h2000_0000);
		wr(OFF_LEN, 32'h0);
		rd_chk(OFF_STAT, 32'h0);
		rd_chk(OFF_NEXT, 32'h1000_000A);
		// overfill with a slow host, refused relaunch, stalled drain
		slow <= 1'h1;
		wr(OFF_LEN, 32'hF000_0040);
		rd_chk(OFF_LEN, 32'h0000_0040);
		wr(OFF_LEN, 32'h8);
		wait_reg(OFF_STAT, 32'h3, 32'h3);
		rd_chk(OFF_FILL, 32'(2 * DEPTH));
		ctl(1'h0, 3'h1, 4'h8);
		for (n = 0; n < 300 && drained < 4; n++) @(posedge aclk);
		repeat (20) @(posedge aclk);
		cmp_word("drained", 32'h4, 32'(drained));
		ctl(1'h0, 3'h7, 4'h8);
		ctl(1'h0, 3'h7, 4'h8);
		wait_reg(OFF_STAT, 32'h1, 32'h0);
		wait_reg(OFF_FILL, 32'hFFFF_FFFF, 32'h0);
		rd_chk(OFF_NEXT, 32'h2000_0040);
		cmp_word("drained", 32'd37, 32'(drained));
		cmp_word("left", 32'h0, 32'(m_vals.size()));
		// tally clears per mode, error trigger keeps the count
		foreach (steps[i]) begin
			ctl(steps[i][4], 3'h0, steps[i][3:0]);
			rd_chk(OFF_TALLY, 32'(m_tally));
		end
		report_and_stop();
	end
endmodule
